// ### accel_readout_pkg.sv
// constants for the acceleration sample readout block
`default_nettype none
package accel_readout_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_SAMPLE_STATUS = 8'h00;
    localparam logic [7:0] ADDR_X_HIGH        = 8'h01;
    localparam logic [7:0] ADDR_X_LOW         = 8'h02;
    localparam logic [7:0] ADDR_Y_HIGH        = 8'h03;
    localparam logic [7:0] ADDR_Y_LOW         = 8'h04;
    localparam logic [7:0] ADDR_Z_HIGH        = 8'h05;
    localparam logic [7:0] ADDR_Z_LOW         = 8'h06;
    localparam logic [7:0] ADDR_LAST_DATA     = 8'h06;
    localparam logic [7:0] ADDR_RESET         = 8'h00;
    // ------------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------------
    localparam int READY_LSB        = 0;
    localparam int ANY_READY_BIT    = 3;
    localparam int OVERWRITE_LSB    = 4;
    localparam int ANY_OVERWRITE_BIT = 7;
    localparam int AXES             = 3;
    localparam int SAMPLE_BITS      = 10;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET   = 8'h00;
    localparam logic [9:0] SAMPLE_RESET = 10'h000;
endpackage
`default_nettype wire

// ### accel_sample_status_readout.sv
// sample hold, status flags and burst read sequencing for a three-axis sensor
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Overview of operation
// - fast read burst skips every low-byte register
// - normal burst gives all six bytes in order
// - status bits: overwrites high nibble, readies low nibble
// - combined overwrite sets when any axis overwritten
// - combined overwrite clears after all three highs read
// - axis overwrite on unread sample, clears on high read
// - combined ready sets on any sample, clears after highs
// - axis ready sets on sample, clears on high read
// - samples held as two's complement values
// - x high byte holds sample bits nine to two
// - six data registers auto-increment from one to six
// - low byte readable only right after its high
// - low byte frozen at high read for pairing
// ----------------------------------------------------------------------
module accel_sample_status_readout
    import accel_readout_pkg::*;
#(
    parameter int WIDTH = SAMPLE_BITS
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             sample_valid,
    input  wire logic [WIDTH-1:0] sample_x,
    input  wire logic [WIDTH-1:0] sample_y,
    input  wire logic [WIDTH-1:0] sample_z,
    input  wire logic [2:0]       sample_axis_en,
    output logic                  sample_ready,
    input  wire logic             fast_read,
    input  wire logic             addr_load,
    input  wire logic [7:0]       addr_in,
    input  wire logic             rd_req,
    output logic [7:0]            rd_data,
    output logic                  rd_valid
);
    // ------------------------------------------------------------------
    // two-entry sample buffer
    // ------------------------------------------------------------------
    localparam int ENTRY = 3 * WIDTH + 3;
    logic [ENTRY-1:0] buf_mem [2];
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       buf_count;
    logic [1:0]       next_count;
    logic             push;
    logic             pop;
    logic             drain_ready;
    logic [ENTRY-1:0] head;

    // the drain stalls in a read cycle so a read and an update never collide
    assign drain_ready = !rd_req;
    assign push        = sample_valid && sample_ready;
    assign pop         = (buf_count != 2'd0) && drain_ready;
    assign next_count  = buf_count + {1'b0, push} - {1'b0, pop};
    assign head        = buf_mem[rd_ptr];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr       <= 1'b0;
            rd_ptr       <= 1'b0;
            buf_count    <= 2'd0;
            sample_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= !wr_ptr;
            end
            if (pop) begin
                rd_ptr <= !rd_ptr;
            end
            buf_count    <= next_count;
            sample_ready <= next_count != 2'd2;
        end
    end

    // storage has no reset: an entry is only read after it was written
    always_ff @(posedge clk) begin
        if (push) begin
            buf_mem[wr_ptr] <= {sample_axis_en, sample_z, sample_y, sample_x};
        end
    end

    // ------------------------------------------------------------------
    // sample registers and per-axis flags
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] axis_data [AXES];
    logic [AXES-1:0]  axis_ready;
    logic [AXES-1:0]  axis_over;
    logic [AXES-1:0]  high_seen;
    logic [AXES-1:0]  high_hit;
    logic [AXES-1:0]  arrive;
    logic             any_ready;
    logic             any_over;
    logic [7:0]       addr;
    logic [7:0]       low_hold;
    logic [1:0]       last_high;
    logic             last_was_high;
    logic             all_read;

    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            assign arrive[g]   = pop && head[3*WIDTH+g];
            // a read refused by an address load clears nothing
            assign high_hit[g] = rd_req && !addr_load && (addr == ADDR_X_HIGH + 8'(2*g));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    axis_data[g]  <= WIDTH'(SAMPLE_RESET);
                    axis_ready[g] <= 1'b0;
                    axis_over[g]  <= 1'b0;
                end else begin
                    if (arrive[g]) begin
                        // kept as raw two's complement, no sign handling needed
                        axis_data[g] <= head[g*WIDTH +: WIDTH];
                    end
                    if (arrive[g]) begin
                        axis_ready[g] <= 1'b1;
                    end else if (high_hit[g]) begin
                        axis_ready[g] <= 1'b0;
                    end
                    if (arrive[g] && axis_ready[g]) begin
                        axis_over[g] <= 1'b1;
                    end else if (high_hit[g]) begin
                        axis_over[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // combined flags
    // ------------------------------------------------------------------
    assign all_read = &(high_seen | high_hit);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_seen <= 3'b000;
            any_ready <= 1'b0;
            any_over  <= 1'b0;
        end else begin
            // a fresh sample on an axis means its high byte must be read again
            if (all_read) begin
                high_seen <= 3'b000;
            end else begin
                high_seen <= (high_seen | high_hit) & ~arrive;
            end
            // a new sample in the clearing cycle wins over the clear
            if (|arrive) begin
                any_ready <= 1'b1;
            end else if (all_read) begin
                any_ready <= 1'b0;
            end
            if (|(arrive & axis_ready)) begin
                any_over <= 1'b1;
            end else if (all_read) begin
                any_over <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // burst read sequencing
    // ------------------------------------------------------------------
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fast);
        logic [7:0] n;
        n = a + 8'd1;
        // fast read walks status, then the high bytes only
        if (fast && (a == ADDR_X_HIGH || a == ADDR_Y_HIGH)) begin
            n = a + 8'd2;
        end else if (fast && a == ADDR_Z_HIGH) begin
            n = ADDR_SAMPLE_STATUS;
        end else if (a == ADDR_LAST_DATA) begin
            n = ADDR_SAMPLE_STATUS;
        end
        return n;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr          <= ADDR_RESET;
            rd_data       <= BYTE_RESET;
            rd_valid      <= 1'b0;
            low_hold      <= BYTE_RESET;
            last_high     <= 2'd0;
            last_was_high <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            if (addr_load) begin
                addr          <= addr_in;
                last_was_high <= 1'b0;
            end else if (rd_req) begin
                addr          <= next_addr(addr, fast_read);
                last_was_high <= |high_hit;
                if (addr == ADDR_SAMPLE_STATUS) begin
                    rd_data <= {any_over, axis_over, any_ready, axis_ready};
                end else if (addr == ADDR_X_HIGH) begin
                    rd_data  <= axis_data[0][WIDTH-1 -: 8];
                    low_hold <= {axis_data[0][1:0], 6'b00_0000};
                    last_high <= 2'd0;
                end else if (addr == ADDR_Y_HIGH) begin
                    rd_data  <= axis_data[1][WIDTH-1 -: 8];
                    low_hold <= {axis_data[1][1:0], 6'b00_0000};
                    last_high <= 2'd1;
                end else if (addr == ADDR_Z_HIGH) begin
                    rd_data  <= axis_data[2][WIDTH-1 -: 8];
                    low_hold <= {axis_data[2][1:0], 6'b00_0000};
                    last_high <= 2'd2;
                end else if ((addr == ADDR_X_LOW || addr == ADDR_Y_LOW || addr == ADDR_Z_LOW)
                             && last_was_high && addr == ADDR_X_LOW + {5'd0, last_high, 1'b0}) begin
                    rd_data <= low_hold;
                end else begin
                    // out-of-sequence low reads and other addresses give zero
                    rd_data <= BYTE_RESET;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### accel_readout_monitor.sv
// port checker for the sample readout block
`timescale 1ns/1ns
`default_nettype none
module accel_readout_monitor
    import accel_readout_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       fast_read,
    input wire logic       addr_load,
    input wire logic [7:0] addr_in,
    input wire logic       rd_req,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid
);
    logic [7:0] a;
    wire        rd = rd_req && !addr_load;
    // burst address shadow, so byte checks know which register answered
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) a <= ADDR_RESET;
        else if (addr_load) a <= addr_in;
        else if (rd_req) a <= (a == ADDR_LAST_DATA || (fast_read && a == ADDR_Z_HIGH)) ? ADDR_RESET
            : a + ((fast_read && a[0] && a < ADDR_Y_LOW) ? 8'h02 : 8'h01);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence st; rd && a == ADDR_SAMPLE_STATUS; endsequence
    read_answer_a: assert property (rd |=> rd_valid) else $error("no answer");
    answer_cause_a: assert property (rd_valid |-> $past(rd_req)) else $error("stray answer");
    data_hold_a: assert property (!rd_valid |-> $stable(rd_data)) else $error("data moved");
    ready_sum_a: assert property (st |=> !rd_data[2:0] || rd_data[3]) else $error("ready sum");
    over_sum_a: assert property (st |=> !rd_data[6:4] || rd_data[7]) else $error("overwrite sum");
    over_ready_a: assert property (st |=> !(rd_data[6:4] & ~rd_data[2:0])) else $error("lone overwrite");
    low_tail_a: assert property (rd && a inside {2, 4, 6} |=> !rd_data[5:0]) else $error("low tail");
    reserved_zero_a: assert property (rd && a > ADDR_LAST_DATA |=> !rd_data) else $error("reserved");
endmodule
bind accel_sample_status_readout accel_readout_monitor mon_u (.clk(clk), .rst_n(rst_n), .fast_read(fast_read),
    .addr_load(addr_load), .addr_in(addr_in), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));
`default_nettype wire

// ### host_reader.sv
// host model issuing burst loads and byte reads
`timescale 1ns/1ns
`default_nettype none
module host_reader (
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    output logic            addr_load,
    output logic [7:0]      addr_in,
    output logic            rd_req
);
    initial {addr_load, addr_in, rd_req} = 10'h000;
    // address bus inverted once released, so stale values never look valid
    task automatic read(input logic ld, input logic [7:0] a, output logic [7:0] d);
        @(negedge clk) {addr_load, addr_in} = {ld, a};
        if (ld) @(negedge clk) {addr_load, addr_in} = {1'b0, ~a};
        @(negedge clk) rd_req = 1'b1;
        @(negedge clk) rd_req = 1'b0;
        d = rd_data;
    endtask
endmodule
`default_nettype wire

// ### accel_sample_status_readout_tb_top.sv
// self-checking bench for the sample readout block
`timescale 1ns/1ns
`default_nettype none
module accel_sample_status_readout_tb_top
    import accel_readout_pkg::*;
;
    logic       clk = 1'b0, rst_n = 1'b0, sv = 1'b0, fast = 1'b0, sr, rv, ld, rq;
    logic [9:0] sx = 10'h000, sy = 10'h000, sz = 10'h000, s [3] = '{10'h2A5, 10'h15A, 10'h3FF};
    logic [2:0] en = 3'h0;
    logic [7:0] ai, rdat;
    int         n_mismatch = 0, compares = 0;
    always #50 clk = ~clk;
    accel_sample_status_readout dut_u (.clk(clk), .rst_n(rst_n), .sample_valid(sv), .sample_x(sx), .sample_y(sy),
        .sample_z(sz), .sample_axis_en(en), .sample_ready(sr), .fast_read(fast), .addr_load(ld), .addr_in(ai),
        .rd_req(rq), .rd_data(rdat), .rd_valid(rv));
    host_reader host_u (.clk(clk), .rd_data(rdat), .addr_load(ld), .addr_in(ai), .rd_req(rq));
    task automatic check(input string name, input logic [7:0] seen, want);
        compares++;
        if (seen !== want) n_mismatch++;
        if (seen !== want) $display("unexpected %s expected %h seen %h", name, want, seen);
    endtask
    task automatic rd(input logic load, input logic [7:0] a, want);
        logic [7:0] d;
        host_u.read(load, a, d);
        check("rd_data", d, want);
        check("rd_valid", {7'h00, rv}, 8'h01);
    endtask
    // buffer is empty here, so the word is taken at the first edge
    task automatic push(input logic [9:0] x, y, z, input logic [2:0] e);
        @(negedge clk) {sx, sy, sz, en, sv} = {x, y, z, e, 1'b1};
        check("sample_ready", {7'h00, sr}, 8'h01);
        @(negedge clk) {sx, sy, sz, sv} = {~x, ~y, ~z, 1'b0};
        repeat (3) @(negedge clk);
    endtask
    task automatic print_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200_000 n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        rd(1, ADDR_SAMPLE_STATUS, STATUS_RESET);
        push(s[2], s[2], s[2], 3'h7);
        push(s[0], s[1], s[2], 3'h7);
        rd(1, ADDR_SAMPLE_STATUS, 8'hFF);
        for (int i = 0; i < 6; i++) rd(0, 8'h00, i[0] ? {s[i / 2][1:0], 6'h00} : s[i / 2][9:2]);
        rd(0, 8'h00, STATUS_RESET);
        $display("burst test done");
        push(s[1], s[1], s[1], 3'h7);
        push(s[2], s[1], s[0], 3'h1);
        rd(1, ADDR_SAMPLE_STATUS, 8'h9F);
        rd(1, ADDR_X_HIGH, s[2][9:2]);
        push(s[0], s[0], s[0], 3'h1);
        rd(0, 8'h00, {s[2][1:0], 6'h00});
        rd(1, ADDR_SAMPLE_STATUS, 8'h8F);
        rd(1, ADDR_Y_LOW, BYTE_RESET);
        rd(1, 8'h07, BYTE_RESET);
        $display("flag test done");
        fast = 1'b1;
        rd(1, ADDR_X_HIGH, s[0][9:2]);
        rd(0, 8'h00, s[1][9:2]);
        rd(0, 8'h00, s[1][9:2]);
        rd(0, 8'h00, STATUS_RESET);
        rd(0, 8'h00, s[0][9:2]);
        $display("fast test done");
        print_verdict();
    end
endmodule
`default_nettype wire
